/* design/mpsi_defs.svh */
// constants of the phy-side pin interface: timing counts, pin vector layout, mdio frame layout
// assumes the reference clock figure below matches the clock fed to ref_clk
`ifndef MPSI_DEFS_SVH
`define MPSI_DEFS_SVH

// clock figures in kHz; the mdc half period rounds up so mdc never exceeds its ceiling
`define MPSI_REF_CLK_KHZ       250000
`define MPSI_MDC_MAX_KHZ       2500
`define MPSI_MDC_HALF          ((`MPSI_REF_CLK_KHZ + 2 * `MPSI_MDC_MAX_KHZ - 1) / (2 * `MPSI_MDC_MAX_KHZ))

// domain reset pulse length in link clock cycles
`define MPSI_DOMAIN_RST_CYCLES 3

// transmit buffer depth in words
`define MPSI_TX_FIFO_DEPTH     16
`define MPSI_TX_WORD_W         10
`define MPSI_TX_WORD_LAST      9
`define MPSI_TX_WORD_ERR       8

// low power idle pattern on the transmit bus
`define MPSI_LPI_TXD           8'h01

// layout of the synchronised pin vector
`define MPSI_PIN_W             15
`define MPSI_PIN_TXC           0
`define MPSI_PIN_RXC           1
`define MPSI_PIN_RXD           2
`define MPSI_PIN_DV            10
`define MPSI_PIN_ER            11
`define MPSI_PIN_CRS           12
`define MPSI_PIN_COL           13
`define MPSI_PIN_MDI           14

// management frame layout, msb first
`define MPSI_MDIO_FRAME_BITS   64
`define MPSI_MDIO_DRIVE_BITS   46
`define MPSI_MDIO_DATA_FIRST   48
`define MPSI_MDIO_PREAMBLE     32'hFFFF_FFFF
`define MPSI_MDIO_START        2'h1
`define MPSI_MDIO_OP_RD        2'h2
`define MPSI_MDIO_OP_WR        2'h1
`define MPSI_MDIO_TA_RD        2'h3
`define MPSI_MDIO_TA_WR        2'h2

`endif

/* design/mpsi_pkg.sv */
// types shared by the phy-side interface modules
// assumes mpsi_defs.svh is on the include path
package mpsi_pkg;

  // static interface selection; reset mode runs on the internal clock only
  typedef enum logic [1:0] {
    MPSI_MODE_RESET,
    MPSI_MODE_RGMII,
    MPSI_MODE_RMII,
    MPSI_MODE_GMII_MII
  } mpsi_mode_e;

  // transmit sequencer states
  typedef enum logic [1:0] {
    MPSI_TX_IDLE,
    MPSI_TX_DATA,
    MPSI_TX_DROP
  } mpsi_tx_e;

endpackage

/* design/mpsi_fifo.sv */
// synchronous fifo with valid/ready on both sides
// assumes one clock; depth must be a power of two
`timescale 1ns/1ps
module mpsi_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // pointer arithmetic wraps, so only powers of two are served
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("mpsi_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } mpsi_fifo_s;

  mpsi_fifo_s st_r;
  mpsi_fifo_s st_nxt;
  logic       full;
  logic       empty;

  // extra pointer bit tells full from empty
  assign full      = (st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
  assign empty     = (st_r.wp == st_r.rp);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st_r.mem[st_r.rp[AW-1:0]];

  // push and pop
  always_comb begin
    st_nxt = st_r;
    if (in_valid && !full) begin
      st_nxt.mem[st_r.wp[AW-1:0]] = in_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

/* design/mpsi_mdio.sv */
// management frame engine: clause-22 style read and write with divided mdc
// assumes mdi is already synchronised to clk; outputs all come from flops on clk
`timescale 1ns/1ps
`include "mpsi_defs.svh"
module mpsi_mdio
  import mpsi_pkg::*;
#(
  parameter int MDC_HALF = `MPSI_MDC_HALF
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic        read,
  input  wire logic [4:0]  phy_addr,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] wdata,
  output logic             busy,
  output logic [15:0]      rdata,
  output logic             done,
  output logic             mdc,
  input  wire logic        mdi,
  output logic             mdo,
  output logic             mdo_oe
);
  generate
    if (MDC_HALF < 1 || MDC_HALF > 128) begin : g_bad_half
      $error("mpsi_mdio: MDC_HALF must lie in 1..128");
    end
  endgenerate

  typedef struct packed {
    logic        busy;
    logic        rd;
    logic [6:0]  div;
    logic [6:0]  bitn;
    logic        mdc;
    logic        mdo;
    logic        oe;
    logic [63:0] sh;
    logic [15:0] rdata;
    logic        done;
  } mpsi_mdio_s;

  mpsi_mdio_s st_r;
  mpsi_mdio_s st_nxt;

  assign busy   = st_r.busy;
  assign rdata  = st_r.rdata;
  assign done   = st_r.done;
  assign mdc    = st_r.mdc;
  assign mdo    = st_r.mdo;
  assign mdo_oe = st_r.oe;

  // mdc only toggles during a frame, so it is aperiodic; data moves on its falling edge
  always_comb begin
    logic [6:0] nb;
    nb = 7'h0;
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (!st_r.busy) begin
      if (start) begin
        st_nxt.busy = 1'b1;
        st_nxt.rd   = read;
        st_nxt.sh   = {`MPSI_MDIO_PREAMBLE, `MPSI_MDIO_START,
                       read ? `MPSI_MDIO_OP_RD : `MPSI_MDIO_OP_WR, phy_addr, reg_addr,
                       read ? `MPSI_MDIO_TA_RD : `MPSI_MDIO_TA_WR, read ? 16'h0000 : wdata};
        st_nxt.mdo  = 1'b1;                           // preamble starts with a one
        st_nxt.oe   = 1'b1;
        st_nxt.div  = 7'h0;
        st_nxt.bitn = 7'h0;
        st_nxt.mdc  = 1'b0;
      end
    end else if (st_r.div == 7'(MDC_HALF - 1)) begin
      st_nxt.div = 7'h0;
      st_nxt.mdc = !st_r.mdc;
      if (!st_r.mdc) begin
        // rising mdc: the phy drives data bits while we have released the line
        if (st_r.rd && st_r.bitn >= 7'(`MPSI_MDIO_DATA_FIRST)) begin
          st_nxt.rdata = {st_r.rdata[14:0], mdi};
        end
      end else if (st_r.bitn == 7'(`MPSI_MDIO_FRAME_BITS - 1)) begin
        st_nxt.busy = 1'b0;
        st_nxt.oe   = 1'b0;
        st_nxt.mdo  = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        nb          = st_r.bitn + 7'h1;
        st_nxt.bitn = nb;
        st_nxt.sh   = {st_r.sh[62:0], 1'b0};
        // enable only while our bit is valid; released from turnaround on a read
        st_nxt.oe   = !st_r.rd || (nb < 7'(`MPSI_MDIO_DRIVE_BITS));
        st_nxt.mdo  = st_nxt.oe ? st_r.sh[62] : 1'b0;
      end
    end else begin
      st_nxt.div = st_r.div + 7'h1;
    end
  end

  // every management output is a flop on the one bus clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

/* design/mpsi_top.sv */
// phy-facing pin interface of one mac: gmii/mii/rmii/rgmii data paths, domain resets,
// carrier sense and collision, management pins; transmit words pass a 16-word fifo
// assumes ref_clk at 250 MHz; phy clocks and pins are sampled, not used as clocks
//
// Function
// - drive 8-bit transmit bus; gigabit uses all bits, nibble mode bits 3:0.
// - transmit enable is high while frame data is on the bus, and also for an underrun beat with txd zero and the error flag set.
// - transmit error flags errors and, in gigabit/nibble mode only, signals low power idle.
// - gigabit makes the transmit clock; 10/100 forwards the phy transmit clock.
// - active-low transmit reset output, three transmit clock cycles long.
// - active-low receive reset output, three receive clock cycles long.
// - sample eight receive bits at gigabit, low four in nibble mode.
// - all management outputs are synchronous to the bus clock.
// - management output enable is high while valid bits are driven.
// - management clock comes from a divider, never above 2.5 MHz.
// - lane width 2, 4 or 8 by mode; crs, col and resets only nibble/gigabit.
// - static mode select: reset, reduced-gigabit, reduced-pin, gigabit/nibble.
`timescale 1ns/1ps
`include "mpsi_defs.svh"
module mpsi_top
  import mpsi_pkg::*;
#(
  parameter int TX_FIFO_DEPTH = `MPSI_TX_FIFO_DEPTH,
  parameter int MDC_HALF      = `MPSI_MDC_HALF
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  mpsi_mode_e       mode,
  input  wire logic        gig_speed,
  input  wire logic        half_duplex,
  input  wire logic        lpi_req,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_last,
  input  wire logic        tx_err,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic             tx_collision,
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  output logic             rx_err,
  output logic             rx_end,
  output logic             rx_frame_err,
  output logic             carrier_sense,
  output logic             collision,
  input  wire logic        phy_tx_clk_in,
  output logic             phy_tx_clk_out,
  output logic [7:0]       phy_txd,
  output logic             phy_txen,
  output logic             phy_txer,
  output logic             phy_tx_rst_n,
  input  wire logic        phy_rx_clk_in,
  input  wire logic [7:0]  phy_rxd,
  input  wire logic        phy_rxdv,
  input  wire logic        phy_rxer,
  output logic             phy_rx_rst_n,
  input  wire logic        phy_crs,
  input  wire logic        phy_col,
  input  wire logic        mdio_start,
  input  wire logic        mdio_read,
  input  wire logic [4:0]  mdio_phy_addr,
  input  wire logic [4:0]  mdio_reg_addr,
  input  wire logic [15:0] mdio_wdata,
  output logic             mdio_busy,
  output logic [15:0]      mdio_rdata,
  output logic             mdio_done,
  output logic             mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe
);
  localparam int PW = `MPSI_PIN_W;
  localparam int TW = `MPSI_TX_WORD_W;

  typedef struct packed {
    logic [PW-1:0] s1;
    logic [PW-1:0] s2;
    logic [PW-1:0] s3;
    logic [PW-1:0] flt;
    logic          txclk;
    mpsi_tx_e      tx_state;
    logic [1:0]    tx_beat;
    logic [TW-1:0] tx_word;
    logic [7:0]    txd;
    logic          txen;
    logic          txer;
    logic          tx_coll;
    logic [1:0]    tx_rcnt;
    logic          tx_rst_n;
    logic [1:0]    rx_rcnt;
    logic          rx_rst_n;
    logic          rx_in;
    logic [1:0]    rx_beat;
    logic [7:0]    rx_byte;
    logic          rx_errs;
    logic [7:0]    rx_data;
    logic          rx_valid;
    logic          rx_err;
    logic          rx_end;
    logic          rx_ferr;
    mpsi_mode_e    mode_q;
    logic          gig_q;
  } mpsi_top_s;

  mpsi_top_s     st_r;
  mpsi_top_s     st_nxt;
  logic [PW-1:0] pins;
  logic [TW-1:0] fifo_data;
  logic          fifo_vld;
  logic          fifo_pop;

  // last beat index per byte: four 2-bit beats, two nibbles or one byte
  function automatic logic [1:0] beat_last(input mpsi_mode_e m, input logic gig);
    if (m == MPSI_MODE_RMII) begin
      beat_last = 2'h3;
    end else if (m == MPSI_MODE_GMII_MII && gig) begin
      beat_last = 2'h0;
    end else begin
      beat_last = 2'h1;
    end
  endfunction

  // slice of a byte carried in one beat, zero in the unused lanes
  function automatic logic [7:0] lane_slice(input logic [7:0] b, input logic [1:0] beat,
                                            input mpsi_mode_e m, input logic gig);
    if (m == MPSI_MODE_RMII) begin
      lane_slice = {6'h00, b[{beat, 1'b0} +: 2]};
    end else if (m == MPSI_MODE_GMII_MII && gig) begin
      lane_slice = b;
    end else begin
      lane_slice = beat[0] ? {4'h0, b[7:4]} : {4'h0, b[3:0]};
    end
  endfunction

  assign pins = {mdio_in, phy_col, phy_crs, phy_rxer, phy_rxdv, phy_rxd,
                 phy_rx_clk_in, phy_tx_clk_in};

  // transmit words wait here; tx_ready stalls the source when the link drains slowly
  mpsi_fifo #(
    .W     (TW),
    .DEPTH (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (ref_clk),
    .resetn    (resetn),
    .in_data   ({tx_last, tx_err, tx_data}),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_vld),
    .out_ready (fifo_pop)
  );

  mpsi_mdio #(
    .MDC_HALF (MDC_HALF)
  ) u_mdio (
    .clk      (ref_clk),
    .resetn   (resetn),
    .start    (mdio_start),
    .read     (mdio_read),
    .phy_addr (mdio_phy_addr),
    .reg_addr (mdio_reg_addr),
    .wdata    (mdio_wdata),
    .busy     (mdio_busy),
    .rdata    (mdio_rdata),
    .done     (mdio_done),
    .mdc      (mdc),
    .mdi      (st_r.flt[`MPSI_PIN_MDI]),
    .mdo      (mdio_out),
    .mdo_oe   (mdio_oe)
  );

  // register-sourced outputs, collision also gated by the half_duplex input; crs and col are hidden outside gigabit/nibble mode
  assign phy_tx_clk_out = st_r.txclk;
  assign phy_txd        = st_r.txd;
  assign phy_txen       = st_r.txen;
  assign phy_txer       = st_r.txer;
  assign phy_tx_rst_n   = st_r.tx_rst_n;
  assign phy_rx_rst_n   = st_r.rx_rst_n;
  assign tx_collision   = st_r.tx_coll;
  assign rx_data        = st_r.rx_data;
  assign rx_valid       = st_r.rx_valid;
  assign rx_err         = st_r.rx_err;
  assign rx_end         = st_r.rx_end;
  assign rx_frame_err   = st_r.rx_ferr;
  assign carrier_sense  = st_r.flt[`MPSI_PIN_CRS] && (st_r.mode_q == MPSI_MODE_GMII_MII);
  assign collision      = st_r.flt[`MPSI_PIN_COL] && (st_r.mode_q == MPSI_MODE_GMII_MII)
                          && half_duplex;

  // next state of the whole block
  always_comb begin
    logic [PW-1:0] agree;
    logic          mode_gm;
    logic          mode_ok;
    logic          tx_fall;
    logic          tx_rise;
    logic          rx_rise;
    logic          chg;
    logic          crs_busy;
    logic          coll;
    logic          go_data;
    logic [1:0]    lb;
    logic [7:0]    rxd;
    logic [7:0]    nbyte;
    logic          er;
    st_nxt   = st_r;
    fifo_pop = 1'b0;
    mode_gm  = (mode == MPSI_MODE_GMII_MII);
    mode_ok  = (mode != MPSI_MODE_RESET);
    lb       = beat_last(mode, gig_speed);

    // pins pass three flops; a level counts once stages two and three agree
    st_nxt.s1  = pins;
    st_nxt.s2  = st_r.s1;
    st_nxt.s3  = st_r.s2;
    agree      = ~(st_r.s2 ^ st_r.s3);
    st_nxt.flt = (agree & st_r.s2) | (~agree & st_r.flt);

    // transmit clock: divided ref_clk at gigabit and in reset mode, else forwarded
    if ((mode_gm && gig_speed) || !mode_ok) begin
      st_nxt.txclk = !st_r.txclk;
    end else begin
      st_nxt.txclk = st_r.flt[`MPSI_PIN_TXC];
    end
    tx_fall = st_r.txclk && !st_nxt.txclk;
    tx_rise = !st_r.txclk && st_nxt.txclk;
    rx_rise = st_nxt.flt[`MPSI_PIN_RXC] && !st_r.flt[`MPSI_PIN_RXC];

    // domain resets restart on a mode or speed change, since the clocks change too
    st_nxt.mode_q = mode;
    st_nxt.gig_q  = gig_speed;
    chg = (mode != st_r.mode_q) || (gig_speed != st_r.gig_q) || !mode_gm;
    if (chg) begin
      st_nxt.tx_rcnt  = 2'h0;
      st_nxt.tx_rst_n = 1'b0;
      st_nxt.rx_rcnt  = 2'h0;
      st_nxt.rx_rst_n = 1'b0;
    end else begin
      if (tx_rise && !st_r.tx_rst_n) begin
        if (st_r.tx_rcnt == 2'(`MPSI_DOMAIN_RST_CYCLES - 1)) begin
          st_nxt.tx_rst_n = 1'b1;
        end else begin
          st_nxt.tx_rcnt = st_r.tx_rcnt + 2'h1;
        end
      end
      if (rx_rise && !st_r.rx_rst_n) begin
        if (st_r.rx_rcnt == 2'(`MPSI_DOMAIN_RST_CYCLES - 1)) begin
          st_nxt.rx_rst_n = 1'b1;
        end else begin
          st_nxt.rx_rcnt = st_r.rx_rcnt + 2'h1;
        end
      end
    end

    // transmit: outputs move on the falling edge of the transmit clock output
    crs_busy = half_duplex && mode_gm && st_r.flt[`MPSI_PIN_CRS];
    coll     = half_duplex && mode_gm && st_r.flt[`MPSI_PIN_COL];
    go_data  = (st_r.tx_state == MPSI_TX_DATA) ||
               (st_r.tx_state == MPSI_TX_IDLE && mode_ok && fifo_vld && !crs_busy);
    st_nxt.tx_coll = 1'b0;
    case (st_r.tx_state)
      MPSI_TX_IDLE, MPSI_TX_DATA: begin
        if (tx_fall && !go_data) begin
          // idle: enable low; error with the fixed pattern marks low power idle
          st_nxt.txen = 1'b0;
          st_nxt.txer = lpi_req && mode_gm;
          st_nxt.txd  = (lpi_req && mode_gm) ? `MPSI_LPI_TXD : 8'h00;
          st_nxt.tx_beat = 2'h0;
        end else if (tx_fall && st_r.tx_state == MPSI_TX_DATA && coll) begin
          st_nxt.txen     = 1'b0;
          st_nxt.txer     = 1'b0;
          st_nxt.txd      = 8'h00;
          st_nxt.tx_coll  = 1'b1;
          st_nxt.tx_beat  = 2'h0;
          st_nxt.tx_state = (st_r.tx_beat != 2'h0 && st_r.tx_word[`MPSI_TX_WORD_LAST]) ?
                            MPSI_TX_IDLE : MPSI_TX_DROP;
        end else if (tx_fall && st_r.tx_beat == 2'h0) begin
          st_nxt.tx_state = MPSI_TX_DATA;
          st_nxt.txen     = 1'b1;
          if (fifo_vld) begin
            fifo_pop       = 1'b1;
            st_nxt.tx_word = fifo_data;
            st_nxt.txd     = lane_slice(fifo_data[7:0], 2'h0, mode, gig_speed);
            st_nxt.txer    = fifo_data[`MPSI_TX_WORD_ERR];
            if (lb != 2'h0) begin
              st_nxt.tx_beat = 2'h1;
            end else if (fifo_data[`MPSI_TX_WORD_LAST]) begin
              st_nxt.tx_state = MPSI_TX_IDLE;
            end
          end else begin
            // underrun mid-frame: flag it and discard the rest of the frame
            st_nxt.txd      = 8'h00;
            st_nxt.txer     = 1'b1;
            st_nxt.tx_state = MPSI_TX_DROP;
          end
        end else if (tx_fall) begin
          st_nxt.txd  = lane_slice(st_r.tx_word[7:0], st_r.tx_beat, mode, gig_speed);
          st_nxt.txer = st_r.tx_word[`MPSI_TX_WORD_ERR];
          if (st_r.tx_beat == lb) begin
            st_nxt.tx_beat = 2'h0;
            if (st_r.tx_word[`MPSI_TX_WORD_LAST]) begin
              st_nxt.tx_state = MPSI_TX_IDLE;
            end
          end else begin
            st_nxt.tx_beat = st_r.tx_beat + 2'h1;
          end
        end
      end
      MPSI_TX_DROP: begin
        if (tx_fall) begin
          st_nxt.txen = 1'b0;
          st_nxt.txer = 1'b0;
          st_nxt.txd  = 8'h00;
        end
        fifo_pop = fifo_vld;
        if (fifo_vld && fifo_data[`MPSI_TX_WORD_LAST]) begin
          st_nxt.tx_state = MPSI_TX_IDLE;
        end
      end
      default: begin
        st_nxt.tx_state = MPSI_TX_IDLE;
      end
    endcase

    // receive: lanes sampled on the rising edge of the receive clock, low part first
    rxd   = st_r.flt[`MPSI_PIN_RXD +: 8];
    er    = st_r.flt[`MPSI_PIN_ER] && mode_gm;     // error pin only in gigabit/nibble
    nbyte = st_r.rx_byte;
    if (mode == MPSI_MODE_RMII) begin
      nbyte[{st_r.rx_beat, 1'b0} +: 2] = rxd[1:0];
    end else if (mode_gm && gig_speed) begin
      nbyte = rxd;
    end else if (st_r.rx_beat[0]) begin
      nbyte[7:4] = rxd[3:0];
    end else begin
      nbyte[3:0] = rxd[3:0];
    end
    st_nxt.rx_valid = 1'b0;
    st_nxt.rx_end   = 1'b0;
    if (rx_rise && mode_ok) begin
      if (st_r.flt[`MPSI_PIN_DV]) begin
        st_nxt.rx_in   = 1'b1;
        st_nxt.rx_byte = nbyte;
        st_nxt.rx_errs = st_r.rx_errs || er;
        if (st_r.rx_beat == lb) begin
          st_nxt.rx_beat  = 2'h0;
          st_nxt.rx_data  = nbyte;
          st_nxt.rx_valid = 1'b1;
          st_nxt.rx_err   = st_r.rx_errs || er;
        end else begin
          st_nxt.rx_beat = st_r.rx_beat + 2'h1;
        end
      end else if (st_r.rx_in) begin
        // valid dropped: frame over; a leftover part byte counts as an error
        st_nxt.rx_in   = 1'b0;
        st_nxt.rx_end  = 1'b1;
        st_nxt.rx_ferr = st_r.rx_errs || (st_r.rx_beat != 2'h0);
        st_nxt.rx_beat = 2'h0;
        st_nxt.rx_errs = 1'b0;
      end
    end
  end

  // resets land at zero: domain resets asserted, bus idle, divided clock low
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

/* sim/mpsi_top_asserts.sv */
// pin-level checker for mpsi_top, attached by bind
// assumes one clock domain, ref_clk, with resetn active low
`timescale 1ns/1ps
module mpsi_top_asserts
  import mpsi_pkg::*;
#(
  parameter int MDC_HALF = 50
) (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input mpsi_mode_e      mode,
  input wire logic       phy_tx_clk_out,
  input wire logic [7:0] phy_txd,
  input wire logic       phy_txen,
  input wire logic       phy_tx_rst_n,
  input wire logic       phy_rx_rst_n,
  input wire logic       mdc,
  input wire logic       mdio_out,
  input wire logic       mdio_oe,
  input wire logic       mdio_busy,
  input wire logic       mdio_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // reset mode has no phy behind it, so nothing may be sent
  a_reset_mode_quiet: assert property (mode == MPSI_MODE_RESET |-> !phy_txen)
    else $error("transmit enable in reset mode");
  // the phy samples on the other edge, so lanes may only move at a falling point
  a_txd_on_fall: assert property ($changed(phy_txd) || $changed(phy_txen) |-> $fell(phy_tx_clk_out))
    else $error("transmit lanes moved off the falling point");
  a_txrst_mode: assert property (mode != MPSI_MODE_GMII_MII |=> !phy_tx_rst_n)
    else $error("transmit reset released outside gmii/mii");
  a_rxrst_mode: assert property (mode != MPSI_MODE_GMII_MII |=> !phy_rx_rst_n)
    else $error("receive reset released outside gmii/mii");
  a_mdc_high_time: assert property ($rose(mdc) |-> ##MDC_HALF $fell(mdc))
    else $error("mdc high phase length wrong");
  a_oe_in_frame: assert property (mdio_oe |-> mdio_busy)
    else $error("mdio enable outside a frame");
  a_mdo_on_fall: assert property ($changed(mdio_out) |-> $fell(mdc) || $changed(mdio_busy))
    else $error("mdio output moved off mdc fall");
  a_done_at_end: assert property ($fell(mdio_busy) |-> mdio_done)
    else $error("frame ended without done");
endmodule

/* sim/mpsi_phy_model.sv */
// phy model: free 25 MHz link clocks, mii receive frames, mdio read answers
// assumes nibble lanes and a pulled-up mdio line
`timescale 1ns/1ps
module mpsi_phy_model (
  input  wire logic mdc,
  input  wire logic clr,
  output logic      tx_clk,
  output logic      rx_clk,
  output logic [7:0] rxd,
  output logic      rxdv,
  output logic      mdi
);
  localparam logic [15:0] RD_VAL = 16'hC3A5;
  int nfall;
  // both clocks run between frames as a real phy does
  initial begin
    {tx_clk, rx_clk, rxdv, rxd} = '0;
    forever #20 {tx_clk, rx_clk} = ~{tx_clk, rx_clk};
  end
  // one byte, low nibble first, valid without gaps; released lane shows junk
  task automatic send(input logic [7:0] b);
    @(negedge rx_clk) {rxdv, rxd} <= {1'b1, 4'h0, b[3:0]};
    @(negedge rx_clk) rxd <= {4'h0, b[7:4]};
    @(negedge rx_clk) {rxdv, rxd} <= {1'b0, ~b};
  endtask
  // bit k starts after k mdc falls; answer in bits 48..63, pull-up otherwise
  always @(negedge mdc or posedge clr)
    if (clr)
      nfall <= 0;
    else
      nfall <= nfall + 1;
  assign mdi = (nfall >= 48 && nfall < 64) ? RD_VAL[63 - nfall] : 1'b1;
endmodule

/* sim/test_mpsi_top.sv */
// testbench for mpsi_top with the phy model on its pins
// assumes a 250 MHz ref_clk and a shortened mdc divider
`timescale 1ns/1ps
module test_mpsi_top;
  import mpsi_pkg::*;
  logic       ref_clk, resetn, gig_speed, half_duplex, tx_last, tx_valid, phy_crs, phy_col;
  logic       mdio_start, rd, clr, lpi_req, tx_err;
  logic [7:0] tx_data;
  mpsi_mode_e mode;
  wire  [7:0] phy_txd, rx_data, rxd;
  wire [15:0] mdio_rdata;
  wire        tx_ready, rx_valid, rx_end, rx_frame_err, carrier_sense, collision, phy_txen;
  wire        mdc, mdio_out, mdio_oe, mdio_busy, mdio_done, txc, rxc, rxdv, mdi;
  wire        phy_tx_rst_n, phy_rx_rst_n, phy_tx_clk_out, phy_txer;
  int         fails, cmp_count, n;
  mpsi_top #(.MDC_HALF(8)) i_dut (.ref_clk, .resetn, .mode, .gig_speed, .half_duplex,
    .lpi_req, .tx_data, .tx_last, .tx_err, .tx_valid, .tx_ready,
    .tx_collision(), .rx_data, .rx_valid, .rx_err(), .rx_end, .rx_frame_err, .carrier_sense,
    .collision, .phy_tx_clk_in(txc), .phy_tx_clk_out, .phy_txd, .phy_txen, .phy_txer,
    .phy_tx_rst_n, .phy_rx_clk_in(rxc), .phy_rxd(rxd), .phy_rxdv(rxdv), .phy_rxer(1'b0),
    .phy_rx_rst_n, .phy_crs, .phy_col, .mdio_start, .mdio_read(rd), .mdio_phy_addr(5'h01),
    .mdio_reg_addr(5'h02), .mdio_wdata({tx_data, tx_data}), .mdio_busy, .mdio_rdata,
    .mdio_done, .mdc, .mdio_in(mdi), .mdio_out, .mdio_oe);
  mpsi_phy_model m (.mdc, .clr, .tx_clk(txc), .rx_clk(rxc), .rxd, .rxdv, .mdi);
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // a bound used up is a mismatch and ends the run
  task automatic tmo(input int lim);
    if (n >= lim) begin
      fails++;
      final_report();
    end
  endtask
  // reset mode sends nothing, so the buffer fills; gmii/mii then drains it as nibbles
  task automatic t_fifo();
    for (int i = 0; i < 16; i++)
      @(posedge ref_clk)
        {tx_valid, tx_last, tx_err, tx_data} <= {1'b1, i == 15, i == 0, 8'hA0 + 8'(i)};
    @(posedge ref_clk) tx_valid <= 0;
    #1 chk("tx_ready", 0, tx_ready);
    mode <= MPSI_MODE_GMII_MII;
    for (n = 0; n < 500 && phy_txen !== 1; n++) @(posedge ref_clk) #1;
    tmo(500);
    chk("low nibble", 8'h00, phy_txd);
    chk("txer", 1, phy_txer);
    // second beat stands ten cycles from the next falling point; look mid-beat
    repeat (15) @(posedge ref_clk) #1;
    chk("high nibble", 8'h0A, phy_txd);
    for (n = 0; n < 900 && phy_txen !== 0; n++) @(posedge ref_clk) #1;
    tmo(900);
    chk("drained", 1, tx_ready);
    // the domain reset needs three clock rises after the mode change, so look late
    chk("tx reset", 1, phy_tx_rst_n);
    $display("t_fifo done");
  endtask
  task automatic t_rx();
    fork
      m.send(8'h3C);
      for (n = 0; n < 300 && rx_valid !== 1; n++) @(posedge ref_clk) #1;
    join
    tmo(300);
    chk("rx_data", 8'h3C, rx_data);
    chk("rx reset", 1, phy_rx_rst_n);
    for (n = 0; n < 300 && rx_end !== 1; n++) @(posedge ref_clk) #1;
    tmo(300);
    chk("rx_frame_err", 0, rx_frame_err);
    $display("t_rx done");
  endtask
  task automatic t_mdio();
    @(posedge ref_clk) {clr, rd} <= 2'b11;
    @(posedge ref_clk) {clr, mdio_start} <= 2'b01;
    @(posedge ref_clk) mdio_start <= 0;
    #1; // busy rises at this very edge
    for (n = 0; n < 1500 && mdio_busy !== 0; n++) @(posedge ref_clk) #1;
    tmo(1500);
    chk("mdio_rdata", m.RD_VAL, mdio_rdata);
    $display("t_mdio done");
  endtask
  // col counts only in half duplex, both pass synchronisers first
  task automatic t_col();
    @(posedge ref_clk) {half_duplex, phy_col, phy_crs, lpi_req} <= 4'hF;
    repeat (10) @(posedge ref_clk);
    chk("collision", 1, collision);
    chk("carrier_sense", 1, carrier_sense);
    half_duplex <= 0;
    repeat (3) @(posedge ref_clk) #1;
    chk("collision fd", 0, collision);
    chk("lpi txd", 8'h01, phy_txd);
    chk("lpi txer", 1, phy_txer);
    $display("t_col done");
  endtask
  initial begin
    {resetn, gig_speed, half_duplex, tx_last, tx_valid, phy_crs, phy_col} = '0;
    {mdio_start, rd, clr, lpi_req, tx_err, tx_data, fails, cmp_count} = '0;
    mode = MPSI_MODE_RESET;
    repeat (20) @(posedge ref_clk);
    resetn <= 1;
    t_fifo();
    t_rx();
    t_mdio();
    t_col();
    final_report();
  end
endmodule
bind mpsi_top mpsi_top_asserts #(.MDC_HALF(MDC_HALF)) u_chk (.ref_clk, .resetn, .mode,
  .phy_tx_clk_out, .phy_txd, .phy_txen, .phy_tx_rst_n, .phy_rx_rst_n, .mdc, .mdio_out,
  .mdio_oe, .mdio_busy, .mdio_done);
